// ===== core/phj_pkg.sv
package phj_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] PORT_A_DATA_OFS   = 8'h20;
  localparam logic [7:0] PORT_A_INPUT_OFS  = 8'h21;
  localparam logic [7:0] PORT_A_DIR_OFS    = 8'h22;
  localparam logic [7:0] PORT_A_DRIVE_OFS  = 8'h23;
  localparam logic [7:0] PORT_A_PULL_OFS   = 8'h24;
  localparam logic [7:0] PORT_A_POL_OFS    = 8'h25;
  localparam logic [7:0] PORT_A_IE_OFS     = 8'h26;
  localparam logic [7:0] PORT_A_FLAG_OFS   = 8'h27;
  localparam logic [7:0] PORT_B_DATA_OFS   = 8'h28;
  localparam logic [7:0] PORT_B_INPUT_OFS  = 8'h29;
  localparam logic [7:0] PORT_B_DIR_OFS    = 8'h2A;
  localparam logic [7:0] PORT_B_DRIVE_OFS  = 8'h2B;
  localparam logic [7:0] PORT_B_PULL_OFS   = 8'h2C;
  localparam logic [7:0] PORT_B_POL_OFS    = 8'h2D;
  localparam logic [7:0] PORT_B_IE_OFS     = 8'h2E;
  localparam logic [7:0] PORT_B_FLAG_OFS   = 8'h2F;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam logic [7:0] PORT_B_MASK       = 8'hC3;
  localparam int         PIN_SEVEN         = 7;
  localparam int         PIN_SIX           = 6;
  localparam logic [7:0] PORT_A_PULL_RST   = 8'h00;
  localparam logic [7:0] PORT_B_PULL_RST   = 8'hC3;
  localparam logic [7:0] REG_RST           = 8'h00;
  localparam logic [2:0] FILT_SAMPLES      = 3'h4;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_b;
    logic [7:0] reduced;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
  } phj_pad_s;

  // bit order: select, clock, master_out, master_in
  typedef struct packed {
    logic       en;
    logic [3:0] drive;
    logic [3:0] oe;
  } phj_spi_s;

  typedef struct packed {
    logic en;
    logic transmit;
  } phj_can_s;

  typedef struct packed {
    logic en;
    logic clock_out;
    logic data_out;
  } phj_i2c_s;

  localparam phj_pad_s PAD_A_RST = '{8'h00, 8'hFF, 8'h00, PORT_A_PULL_RST, 8'h00};
  localparam phj_pad_s PAD_B_RST = '{8'h00, 8'hFF, 8'h00, PORT_B_PULL_RST, 8'h00};

endpackage

// ===== core/phj_port_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - data read: latch if output, else pin
// - enabled spi owns its four port a pins
// - pins 7..4 spi two, 3..0 spi one
// - input register reads pins, ignores writes
// - direction 1 output, 0 input
// - reads lag direction change by three cycles
// - reduced drive only on output pins
// - port a pull only on inputs, off at reset
// - polarity picks edge and pull direction
// - enable bit unmasks pin interrupt
// - active edge sets the pin flag
// - write one clears flag, zero keeps
// - request when flag and enable both set
// - can b owns pins seven, six first
// - i2c next, with open drain outputs
// - can a below i2c, above gpio
// - peripheral direction leaves stored bits untouched
// - port b implements bits 7, 6, 1, 0
// - port b pull on input or wired-or
// - port b polarity zero pulls up, i2c too
// - edge needs four passive then four active
// - one request per port, any direction
// - reset: port a floating, port b pulled up
module phj_port_ctrl (
  input  wire  logic              MCLK,
  input  wire  logic              RST_B,
  input  wire  logic              CE,
  input  wire  logic [7:0]        REG_ADDR,
  input  wire  logic [7:0]        REG_WDATA,
  input  wire  logic              REG_WR,
  input  wire  logic              REG_RD,
  output logic [7:0]              REG_RDATA,
  input  wire  logic [7:0]        PA_IN,
  input  wire  logic [7:0]        PB_IN,
  output phj_pkg::phj_pad_s       PA_PAD,
  output phj_pkg::phj_pad_s       PB_PAD,
  output logic [7:0]              PA_SYNC,
  output logic [7:0]              PB_SYNC,
  input  wire  phj_pkg::phj_spi_s SPI_ONE,
  input  wire  phj_pkg::phj_spi_s SPI_TWO,
  input  wire  phj_pkg::phj_can_s CAN_A,
  input  wire  phj_pkg::phj_can_s CAN_B,
  input  wire  phj_pkg::phj_i2c_s I2C,
  output logic                    IRQ_A,
  output logic                    IRQ_B
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]       data_a;
    logic [7:0]       dir_a;
    logic [7:0]       drv_a;
    logic [7:0]       pull_a;
    logic [7:0]       pol_a;
    logic [7:0]       ie_a;
    logic [7:0]       flag_a;
    logic [7:0]       sync1_a;
    logic [7:0]       sync2_a;
    logic [7:0]       data_b;
    logic [7:0]       dir_b;
    logic [7:0]       drv_b;
    logic [7:0]       pull_b;
    logic [7:0]       pol_b;
    logic [7:0]       ie_b;
    logic [7:0]       flag_b;
    logic [7:0]       sync1_b;
    logic [7:0]       sync2_b;
    logic [15:0][2:0] pas_cnt;
    logic [15:0][2:0] act_cnt;
    logic [7:0]       rdata;
    logic             irq_a;
    logic             irq_b;
    phj_pkg::phj_pad_s pad_a;
    phj_pkg::phj_pad_s pad_b;
  } phj_state_s;

  phj_state_s       st_r;
  phj_state_s       st_nxt;
  logic [15:0]      smp;
  logic [15:0]      pol16;
  logic [15:0]      passive;
  logic [15:0]      hit;
  logic [15:0][2:0] pas_nxt;
  logic [15:0][2:0] act_nxt;
  logic [7:0]       own_a;
  logic [7:0]       oe_a;
  logic [7:0]       oe_b;
  logic [7:0]       out_b;
  logic [7:0]       wor_b;
  logic [7:0]       i2c_b;
  logic [7:0]       wmask;
  logic [7:0]       wval;

  // ****************************************
  // edge filter, one per pin
  // ****************************************
  assign smp   = {st_r.sync2_b, st_r.sync2_a};
  assign pol16 = {st_r.pol_b, st_r.pol_a};

  // samples come from the synchroniser, so it works for outputs as well
  for (genvar i = 0; i < 16; i++) begin : g_flt
    assign passive[i] = smp[i] != pol16[i];
    assign hit[i]     = !passive[i] && st_r.pas_cnt[i] == phj_pkg::FILT_SAMPLES
                        && st_r.act_cnt[i] == phj_pkg::FILT_SAMPLES - 3'h1;
    // an active blip before four passive samples restarts the count
    assign pas_nxt[i] = passive[i] ?
                        ((st_r.pas_cnt[i] == phj_pkg::FILT_SAMPLES) ?
                         st_r.pas_cnt[i] : st_r.pas_cnt[i] + 3'h1) :
                        ((hit[i] || st_r.pas_cnt[i] != phj_pkg::FILT_SAMPLES) ?
                         3'h0 : st_r.pas_cnt[i]);
    assign act_nxt[i] = (passive[i] || hit[i]) ? 3'h0 :
                        ((st_r.pas_cnt[i] == phj_pkg::FILT_SAMPLES) ?
                         st_r.act_cnt[i] + 3'h1 : st_r.act_cnt[i]);
  end

  // ****************************************
  // pin ownership
  // ****************************************
  // upper nibble spi two, lower nibble spi one
  assign own_a = {{4{SPI_TWO.en}}, {4{SPI_ONE.en}}};
  assign oe_a  = (own_a & {SPI_TWO.oe, SPI_ONE.oe}) | (~own_a & st_r.dir_a);

  always_comb begin
    oe_b  = st_r.dir_b & phj_pkg::PORT_B_MASK;
    out_b = st_r.data_b & phj_pkg::PORT_B_MASK;
    wor_b = 8'h00;
    i2c_b = 8'h00;
    // stored direction bits are never touched here
    if (CAN_B.en) begin
      oe_b[phj_pkg::PIN_SEVEN]  = 1'b1;
      oe_b[phj_pkg::PIN_SIX]    = 1'b0;
      out_b[phj_pkg::PIN_SEVEN] = CAN_B.transmit;
    end else if (I2C.en) begin
      // open drain: only a low is driven
      oe_b[phj_pkg::PIN_SEVEN]  = ~I2C.clock_out;
      oe_b[phj_pkg::PIN_SIX]    = ~I2C.data_out;
      out_b[phj_pkg::PIN_SEVEN] = 1'b0;
      out_b[phj_pkg::PIN_SIX]   = 1'b0;
      wor_b[phj_pkg::PIN_SEVEN] = 1'b1;
      wor_b[phj_pkg::PIN_SIX]   = 1'b1;
      i2c_b[phj_pkg::PIN_SEVEN] = 1'b1;
      i2c_b[phj_pkg::PIN_SIX]   = 1'b1;
    end else if (CAN_A.en) begin
      oe_b[phj_pkg::PIN_SEVEN]  = 1'b1;
      oe_b[phj_pkg::PIN_SIX]    = 1'b0;
      out_b[phj_pkg::PIN_SEVEN] = CAN_A.transmit;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    wmask  = 8'h00;
    wval   = 8'h00;
    // two stages; only the second stage is read anywhere
    st_nxt.sync1_a = PA_IN;
    st_nxt.sync2_a = st_r.sync1_a;
    st_nxt.sync1_b = PB_IN & phj_pkg::PORT_B_MASK;
    st_nxt.sync2_b = st_r.sync1_b;
    st_nxt.pas_cnt = pas_nxt;
    st_nxt.act_cnt = act_nxt;

    // register writes
    if (REG_WR) begin
      wmask = phj_pkg::PORT_B_MASK;
      wval  = REG_WDATA & wmask;
      case (REG_ADDR)
        phj_pkg::PORT_A_DATA_OFS:  st_nxt.data_a = REG_WDATA;
        phj_pkg::PORT_A_DIR_OFS:   st_nxt.dir_a  = REG_WDATA;
        phj_pkg::PORT_A_DRIVE_OFS: st_nxt.drv_a  = REG_WDATA;
        phj_pkg::PORT_A_PULL_OFS:  st_nxt.pull_a = REG_WDATA;
        phj_pkg::PORT_A_POL_OFS:   st_nxt.pol_a  = REG_WDATA;
        phj_pkg::PORT_A_IE_OFS:    st_nxt.ie_a   = REG_WDATA;
        phj_pkg::PORT_A_FLAG_OFS:  st_nxt.flag_a = st_r.flag_a & ~REG_WDATA;
        phj_pkg::PORT_B_DATA_OFS:  st_nxt.data_b = wval;
        phj_pkg::PORT_B_DIR_OFS:   st_nxt.dir_b  = wval;
        phj_pkg::PORT_B_DRIVE_OFS: st_nxt.drv_b  = wval;
        phj_pkg::PORT_B_PULL_OFS:  st_nxt.pull_b = wval;
        phj_pkg::PORT_B_POL_OFS:   st_nxt.pol_b  = wval;
        phj_pkg::PORT_B_IE_OFS:    st_nxt.ie_b   = wval;
        phj_pkg::PORT_B_FLAG_OFS:  st_nxt.flag_b = st_r.flag_b & ~wval;
        // input registers and unmapped offsets drop the write
        default: st_nxt.data_a = st_r.data_a;
      endcase
    end

    // set after clear: an edge in the clearing cycle survives
    st_nxt.flag_a = st_nxt.flag_a | hit[7:0];
    st_nxt.flag_b = st_nxt.flag_b | (hit[15:8] & phj_pkg::PORT_B_MASK);

    // one request per port, for inputs and outputs alike
    st_nxt.irq_a = |(st_nxt.flag_a & st_nxt.ie_a);
    st_nxt.irq_b = |(st_nxt.flag_b & st_nxt.ie_b);

    // register reads, answer in the next cycle
    st_nxt.rdata = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        phj_pkg::PORT_A_DATA_OFS:
          st_nxt.rdata = (st_r.data_a & st_r.dir_a) | (st_r.sync2_a & ~st_r.dir_a);
        phj_pkg::PORT_A_INPUT_OFS: st_nxt.rdata = st_r.sync2_a;
        phj_pkg::PORT_A_DIR_OFS:   st_nxt.rdata = st_r.dir_a;
        phj_pkg::PORT_A_DRIVE_OFS: st_nxt.rdata = st_r.drv_a;
        phj_pkg::PORT_A_PULL_OFS:  st_nxt.rdata = st_r.pull_a;
        phj_pkg::PORT_A_POL_OFS:   st_nxt.rdata = st_r.pol_a;
        phj_pkg::PORT_A_IE_OFS:    st_nxt.rdata = st_r.ie_a;
        phj_pkg::PORT_A_FLAG_OFS:  st_nxt.rdata = st_r.flag_a;
        phj_pkg::PORT_B_DATA_OFS:
          st_nxt.rdata = (st_r.data_b & st_r.dir_b) | (st_r.sync2_b & ~st_r.dir_b);
        phj_pkg::PORT_B_INPUT_OFS: st_nxt.rdata = st_r.sync2_b;
        phj_pkg::PORT_B_DIR_OFS:   st_nxt.rdata = st_r.dir_b;
        phj_pkg::PORT_B_DRIVE_OFS: st_nxt.rdata = st_r.drv_b;
        phj_pkg::PORT_B_PULL_OFS:  st_nxt.rdata = st_r.pull_b;
        phj_pkg::PORT_B_POL_OFS:   st_nxt.rdata = st_r.pol_b;
        phj_pkg::PORT_B_IE_OFS:    st_nxt.rdata = st_r.ie_b;
        phj_pkg::PORT_B_FLAG_OFS:  st_nxt.rdata = st_r.flag_b;
        default:                   st_nxt.rdata = 8'h00;
      endcase
    end

    // pads, registered: one cycle behind the controls
    st_nxt.pad_a.out       = (own_a & {SPI_TWO.drive, SPI_ONE.drive}) | (~own_a & st_r.data_a);
    st_nxt.pad_a.oe_b      = ~oe_a;
    st_nxt.pad_a.reduced   = st_r.drv_a & oe_a;
    st_nxt.pad_a.pull_en   = st_r.pull_a & ~oe_a;
    st_nxt.pad_a.pull_down = st_r.pol_a & st_r.pull_a & ~oe_a;
    st_nxt.pad_b.out       = out_b;
    st_nxt.pad_b.oe_b      = ~oe_b;
    // wired-or outputs keep the pull; push-pull drops it
    st_nxt.pad_b.reduced   = st_r.drv_b & oe_b & ~wor_b;
    st_nxt.pad_b.pull_en   = st_r.pull_b & (~oe_b | wor_b);
    // i2c pins only ever pull up
    st_nxt.pad_b.pull_down = st_r.pol_b & st_r.pull_b & ~oe_b & ~i2c_b;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r        <= '0;
      st_r.pull_b <= phj_pkg::PORT_B_PULL_RST;
      st_r.pull_a <= phj_pkg::PORT_A_PULL_RST;
      st_r.pad_a  <= phj_pkg::PAD_A_RST;
      st_r.pad_b  <= phj_pkg::PAD_B_RST;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;
  assign PA_PAD    = st_r.pad_a;
  assign PB_PAD    = st_r.pad_b;
  assign PA_SYNC   = st_r.sync2_a;
  assign PB_SYNC   = st_r.sync2_b;
  assign IRQ_A     = st_r.irq_a;
  assign IRQ_B     = st_r.irq_b;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B || !CE);

  AST_READ_DATA: assert property (
    REG_RD && REG_ADDR == phj_pkg::PORT_A_DATA_OFS |=> REG_RDATA ==
      (($past(st_r.data_a) & $past(st_r.dir_a)) | ($past(st_r.sync2_a) & ~$past(st_r.dir_a))))
    else $error("port a data read mismatch");
  AST_SPI_OWN: assert property (
    SPI_ONE.en |=> PA_PAD.oe_b[3:0] == ~$past(SPI_ONE.oe))
    else $error("spi one does not own its pins");
  AST_INPUT_READ: assert property (
    REG_RD && REG_ADDR == phj_pkg::PORT_B_INPUT_OFS |=> REG_RDATA == $past(st_r.sync2_b))
    else $error("input register mismatch");
  AST_PULL_INPUT: assert property (
    (PA_PAD.pull_en & ~PA_PAD.oe_b) == 8'h00)
    else $error("pull enabled on driven port a pin");
  AST_EDGE_LEVEL: assert property (
    hit[0] |-> st_r.sync2_a[0] == st_r.pol_a[0] ##1 st_r.flag_a[0])
    else $error("edge did not set flag");
  AST_FLAG_CLEAR: assert property (
    REG_WR && REG_ADDR == phj_pkg::PORT_A_FLAG_OFS && hit[7:0] == 8'h00
      |=> (st_r.flag_a & $past(REG_WDATA)) == 8'h00)
    else $error("flag not cleared by write of one");
  AST_IRQ_TIE: assert property (
    IRQ_B == |(st_r.flag_b & st_r.ie_b))
    else $error("port b request mismatch");
  AST_CANB_DIR: assert property (
    CAN_B.en && !(REG_WR && REG_ADDR == phj_pkg::PORT_B_DIR_OFS)
      |=> !PB_PAD.oe_b[7] && PB_PAD.oe_b[6] && st_r.dir_b == $past(st_r.dir_b))
    else $error("can b pin direction wrong");
  AST_I2C_OD: assert property (
    I2C.en && !CAN_B.en |=> PB_PAD.out[7:6] == 2'b00)
    else $error("i2c pins not open drain");
  AST_B_UNIMPL: assert property (
    REG_RD && REG_ADDR == phj_pkg::PORT_B_PULL_OFS |=> (REG_RDATA & ~phj_pkg::PORT_B_MASK) == 8'h00)
    else $error("unimplemented port b bits read nonzero");
  AST_RDATA_IDLE: assert property (
    !REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data not zero outside a read");
  AST_READ_DATA_B: assert property (
    REG_RD && REG_ADDR == phj_pkg::PORT_B_DATA_OFS |=> REG_RDATA ==
      (($past(st_r.data_b) & $past(st_r.dir_b)) | ($past(st_r.sync2_b) & ~$past(st_r.dir_b))))
    else $error("port b data read mismatch");
  AST_INPUT_READ_A: assert property (
    REG_RD && REG_ADDR == phj_pkg::PORT_A_INPUT_OFS |=> REG_RDATA == $past(st_r.sync2_a))
    else $error("port a input register mismatch");
  AST_INPUT_NO_WRITE: assert property (
    REG_WR && REG_ADDR == phj_pkg::PORT_A_INPUT_OFS
      |=> st_r.data_a == $past(st_r.data_a) && st_r.dir_a == $past(st_r.dir_a))
    else $error("write to input register changed state");
  AST_SPI_TWO_OWN: assert property (
    SPI_TWO.en |=> PA_PAD.oe_b[7:4] == ~$past(SPI_TWO.oe))
    else $error("spi two does not own the upper pins");
  AST_SPI_DRIVE: assert property (
    SPI_ONE.en |=> PA_PAD.out[3:0] == $past(SPI_ONE.drive))
    else $error("spi one output not on its pins");
  AST_GPIO_DIR: assert property (
    !SPI_ONE.en && !SPI_TWO.en |=> PA_PAD.oe_b == ~$past(st_r.dir_a))
    else $error("port a direction not from register");
  AST_REDUCED_OUT: assert property (
    (PA_PAD.reduced & PA_PAD.oe_b) == 8'h00)
    else $error("reduced drive on an input pin");
  AST_PULL_POL: assert property (
    (PA_PAD.pull_down & ~PA_PAD.pull_en) == 8'h00)
    else $error("pull-down without pull enable");
  AST_IE_MASK: assert property (
    st_r.ie_a == 8'h00 |-> !IRQ_A)
    else $error("masked port a flag raised a request");
  AST_IRQ_A: assert property (
    IRQ_A == |(st_r.flag_a & st_r.ie_a))
    else $error("port a request mismatch");
  AST_CANB_TX: assert property (
    CAN_B.en |=> PB_PAD.out[7] == $past(CAN_B.transmit))
    else $error("can b transmit not on pin seven");
  AST_CANA_TX: assert property (
    CAN_A.en && !I2C.en && !CAN_B.en
      |=> PB_PAD.out[7] == $past(CAN_A.transmit) && !PB_PAD.oe_b[7] && PB_PAD.oe_b[6])
    else $error("can a does not own pins seven and six");
  AST_B_IMPL: assert property (
    ((st_r.data_b | st_r.dir_b | st_r.drv_b | st_r.pull_b | st_r.pol_b | st_r.ie_b
      | st_r.flag_b) & ~phj_pkg::PORT_B_MASK) == 8'h00)
    else $error("unimplemented port b bit set");
  AST_WOR_PULL: assert property (
    I2C.en && !CAN_B.en |=> PB_PAD.pull_en[7:6] == $past(st_r.pull_b[7:6]))
    else $error("pull dropped on wired-or pins");
  AST_I2C_PULLUP: assert property (
    I2C.en && !CAN_B.en |=> PB_PAD.pull_down[7:6] == 2'b00)
    else $error("pull-down on i2c pins");
  AST_FOUR_ACTIVE: assert property (
    hit[8] |-> $past(!passive[8]) && $past(!passive[8], 2) && $past(!passive[8], 3))
    else $error("edge taken on fewer than four active samples");

  // the sync check skips the edges right after reset; the pad check fires on the first
  AST_SYNC_DELAY: assert property (
    $past(RST_B) && $past(RST_B, 2)
      |-> {PB_SYNC, PA_SYNC} == {$past(PB_IN & phj_pkg::PORT_B_MASK, 2), $past(PA_IN, 2)})
    else $error("pin levels not two stages late");
  AST_RESET_PADS: assert property (
    $rose(RST_B) |-> PA_PAD.oe_b == 8'hFF && PA_PAD.pull_en == phj_pkg::PORT_A_PULL_RST
      && PB_PAD.pull_en == phj_pkg::PORT_B_PULL_RST && PB_PAD.pull_down == 8'h00)
    else $error("pads not at their reset state");

  COV_EDGE_A: cover property (hit[3] ##1 IRQ_A);
  COV_CLEAR_B: cover property (REG_WR && REG_ADDR == phj_pkg::PORT_B_FLAG_OFS && |st_r.flag_b);
  COV_I2C: cover property (I2C.en && !CAN_B.en ##1 !PB_PAD.oe_b[6]);
  COV_SPI_TWO: cover property (SPI_TWO.en ##1 SPI_TWO.en);
  COV_CANB: cover property (CAN_B.en ##1 !PB_PAD.oe_b[7]);

endmodule

// ===== verification/phj_pin_model.sv
`timescale 1ns/1ps
// ****************************************
// pin model: pad, outside driver, pull
// ****************************************
module phj_pin_model (
  input  wire logic              clk,
  input  wire phj_pkg::phj_pad_s pad,
  input  wire logic [7:0]        ext,
  input  wire logic [7:0]        ext_en,
  output logic      [7:0]        pin
);
  logic [7:0] float_r;

  // a pin nobody holds wanders, so a stale level never passes for a read
  always @(posedge clk) begin
    float_r <= (float_r === 8'hA5) ? 8'h5A : 8'hA5;
  end

  // pad wins over the outside driver; contention is not modelled
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad.oe_b[i]) begin
        pin[i] = pad.out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext[i];
      end else if (pad.pull_en[i]) begin
        pin[i] = ~pad.pull_down[i];
      end else begin
        pin[i] = float_r[i];
      end
    end
  end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic              mclk;
  logic              rst_b;
  logic              reg_wr;
  logic              reg_rd;
  logic              irq_a;
  logic              irq_b;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [7:0]        ext_a, ext_b, pin_a, pin_b, base, m, ex, bm, pa_sync, pb_sync;
  logic [7:0]        dir, dat, drv, pul, pol, d;
  phj_pkg::phj_pad_s pad_a, pad_b, pd;
  phj_pkg::phj_spi_s spi_one, spi_two;
  phj_pkg::phj_can_s can_a, can_b;
  phj_pkg::phj_i2c_s i2c;
  int                fails, n_checks, k;
  logic [7:0]        cfg [10] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
                                  8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E};
  logic [7:0]        exp_oe [4] = '{8'h40, 8'h80, 8'h40, 8'h80};
  logic [7:0]        exp_dr [4] = '{8'h00, 8'h00, 8'h80, 8'h40};

  phj_port_ctrl u_phj_port_ctrl (.MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .PA_IN(pin_a), .PB_IN(pin_b), .PA_PAD(pad_a), .PB_PAD(pad_b),
    .PA_SYNC(pa_sync), .PB_SYNC(pb_sync),
    .SPI_ONE(spi_one), .SPI_TWO(spi_two), .CAN_A(can_a), .CAN_B(can_b), .I2C(i2c),
    .IRQ_A(irq_a), .IRQ_B(irq_b));
  phj_pin_model u_pin_a (.clk(mclk), .pad(pad_a), .ext(ext_a), .ext_en(8'hFF), .pin(pin_a));
  phj_pin_model u_pin_b (.clk(mclk), .pad(pad_b), .ext(ext_b), .ext_en(8'hFF), .pin(pin_b));

  always #50 mclk = ~mclk;

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    @(posedge mclk);
    chk(rd_val, exp);
  endtask
  task automatic set_pin(input int p, input int b, input logic v);
    if (p == 1) begin
      ext_b[b] <= v;
    end else begin
      ext_a[b] <= v;
    end
  endtask
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h20, 8'h21: return ext_a;
      8'h28, 8'h29: return ext_b & phj_pkg::PORT_B_MASK;
      8'h2C: return phj_pkg::PORT_B_PULL_RST;
      default: return phj_pkg::REG_RST;
    endcase
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // passive level, a short pulse that must be ignored, then a real edge
  task automatic edge_run(input int p, input int b, input logic act);
    base = (p == 1) ? 8'h28 : 8'h20;
    bm   = 8'h01 << b;
    wr(base + 8'h02, 8'h00);
    wr(base + 8'h05, act ? bm : 8'h00);
    wr(base + 8'h06, bm);
    set_pin(p, b, ~act);
    tick(14);
    wr(base + 8'h07, 8'hFF);
    rchk(base + 8'h07, 8'h00);
    set_pin(p, b, act);
    tick(3);
    set_pin(p, b, ~act);
    tick(12);
    rchk(base + 8'h07, 8'h00);
    set_pin(p, b, act);
    tick(5);
    @(negedge mclk) chk({7'h00, (p == 1) ? irq_b : irq_a}, 8'h00);
    @(negedge mclk) chk({7'h00, (p == 1) ? irq_b : irq_a}, 8'h01);
    tick(1);
    rchk(base + 8'h07, bm);
    wr(base + 8'h07, ~bm);
    rchk(base + 8'h07, bm);
    wr(base + 8'h06, 8'h00);
    chk({7'h00, (p == 1) ? irq_b : irq_a}, 8'h00);
    wr(base + 8'h07, bm);
    rchk(base + 8'h07, 8'h00);
  endtask

  initial begin
    #(100 * 30000);
    fails++;
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    spi_one = '0;
    spi_two = '0;
    can_a = '0;
    can_b = '0;
    i2c = '0;
    fails = 0;
    n_checks = 0;
    void'($urandom(32'h65B505A2));
    ext_a = 8'($urandom);
    ext_b = 8'($urandom);
    tick(12);
    chk(pad_a.oe_b, 8'hFF);
    chk(pad_a.pull_en, 8'h00);
    chk(pad_b.pull_en & 8'hC3, 8'hC3);
    chk(pad_b.pull_down, 8'h00);
    rst_b <= 1'b1;
    tick(4);
    for (k = 32; k < 49; k++) rchk(k[7:0], rst_val(k[7:0]));
    foreach (cfg[i]) begin
      d = 8'($urandom);
      wr(cfg[i], d);
      rchk(cfg[i], cfg[i][3] ? (d & phj_pkg::PORT_B_MASK) : d);
    end
    // random direction, data and pad settings on both ports
    for (int p = 0; p < 2; p++) begin
      base = (p == 1) ? 8'h28 : 8'h20;
      m = (p == 1) ? phj_pkg::PORT_B_MASK : 8'hFF;
      dir = 8'($urandom) & m;
      dat = 8'($urandom);
      drv = 8'($urandom);
      pul = 8'($urandom);
      pol = 8'($urandom);
      wr(base, dat);
      wr(base + 8'h02, dir);
      wr(base + 8'h03, drv);
      wr(base + 8'h04, pul);
      wr(base + 8'h05, pol);
      wr(base + 8'h01, ~dat);
      tick(3);
      ex = (p == 1) ? ext_b : ext_a;
      pd = (p == 1) ? pad_b : pad_a;
      rchk(base, ((dat & dir) | (ex & ~dir)) & m);
      rchk(base + 8'h01, ((dat & dir) | (ex & ~dir)) & m);
      chk((p == 1) ? pb_sync : pa_sync, ((dat & dir) | (ex & ~dir)) & m);
      chk(pd.oe_b & m, ~dir & m);
      chk(pd.out & dir, dat & dir);
      chk(pd.reduced & m, drv & dir);
      chk(pd.pull_en & m, pul & ~dir & m);
      chk(pd.pull_down & pd.pull_en & m, pol & pul & ~dir & m);
    end
    edge_run(0, $urandom_range(7, 0), 1'b1);
    edge_run(0, $urandom_range(7, 0), 1'b0);
    edge_run(1, 0, 1'b1);
    edge_run(1, 7, 1'b0);
    // routed spi modules take over port a
    spi_one <= phj_pkg::phj_spi_s'({1'b1, 8'($urandom)});
    spi_two <= phj_pkg::phj_spi_s'({1'b1, 8'($urandom)});
    tick(3);
    chk(pad_a.oe_b, ~{spi_two.oe, spi_one.oe});
    chk(pad_a.out & ~pad_a.oe_b, {spi_two.drive, spi_one.drive} & ~pad_a.oe_b);
    spi_one <= '0;
    spi_two <= '0;
    // pins seven and six: can b, i2c, can a, then plain direction
    wr(8'h2D, 8'hC3);
    wr(8'h2A, 8'h40);
    wr(8'h28, 8'hC3);
    wr(8'h2C, 8'hC3);
    for (k = 0; k < 4; k++) begin
      can_b <= '{k == 0, 1'b0};
      i2c   <= '{k < 2, 1'b1, k != 1};
      can_a <= '{k < 3, 1'b1};
      tick(3);
      chk(pad_b.oe_b & 8'hC0, exp_oe[k]);
      chk(pad_b.out & ~pad_b.oe_b & 8'hC0, exp_dr[k]);
      if (k == 1) chk(pad_b.pull_down & 8'hC0, 8'h00);
      if (k == 1) chk(pad_b.pull_en & 8'hC0, 8'hC0);
    end
    rchk(8'h2A, 8'h40);
    test_done();
  end
endmodule
